// ==== timer_ctl_defines.vh ====
// Constants for the two-channel 8-bit timer control block
`ifndef TIMER_CTL_DEFINES_VH
`define TIMER_CTL_DEFINES_VH
// Register indices on the plain register port (4-bit address)
`define ADDR_CONTROL0 4'h0
`define ADDR_CONTROL1 4'h1
`define ADDR_MATCH_A0 4'h2
`define ADDR_MATCH_B0 4'h3
`define ADDR_MATCH_A1 4'h4
`define ADDR_MATCH_B1 4'h5
`define ADDR_COUNT0 4'h6
`define ADDR_COUNT1 4'h7
`define ADDR_FLAGS0 4'h8
`define ADDR_FLAGS1 4'h9
`define ADDR_SRC_SEL 4'hA
`define ADDR_IRQ_STAT 4'hB
`define ADDR_IRQ_MASK 4'hC
// Control field positions
`define BIT_MATCH_B_IE 7
`define BIT_MATCH_A_IE 6
`define BIT_WRAP_IE 5
`define CLR_SEL_HI 4
`define CLR_SEL_LO 3
`define CKS_HI 2
`define CKS_LO 0
// Flag register positions
`define BIT_MATCH_B_FLAG 7
`define BIT_MATCH_A_FLAG 6
`define BIT_WRAP_FLAG 5
// Reset values
`define CONTROL_RST 8'h00
`define MATCH_RST 8'hFF
`define COUNT_RST 8'h00
`define FLAGS_RST 8'h10
`define SRC_SEL_RST 8'h00
// Clear-select codes
`define CLR_NONE 2'h0
`define CLR_MATCH_A 2'h1
`define CLR_MATCH_B 2'h2
`define CLR_EXT 2'h3
// Clock-select codes
`define CKS_STOP0 3'h0
`define CKS_INT_LO 3'h1
`define CKS_INT_MID 3'h2
`define CKS_INT_HI 3'h3
`define CKS_STOP1 3'h4
`define CKS_EXT_RISE 3'h5
`define CKS_EXT_FALL 3'h6
`define CKS_EXT_BOTH 3'h7
// Prescaler taps: bit n toggles with period 2^(n+1) system clocks
`define TAP_DIV2 0
`define TAP_DIV8 2
`define TAP_DIV32 4
`define TAP_DIV64 5
`define TAP_DIV128 6
`define TAP_DIV256 7
`define TAP_DIV1024 9
`define TAP_DIV2048 10
`define PRESCALE_W 11
`endif

// ==== timer_sync.v ====
// Two-flop synchroniser with edge detect for one external pin
`timescale 1ns/10ps
module timer_sync
(
  // Clock and reset
  input wire clk_i,
  input wire resetn_i,
  // Pin and results
  input wire pin_i,
  output wire rise_o,
  output wire fall_o
);
  reg meta_ff;
  reg sync_ff;
  reg prev_ff;

  // First flop feeds only the second; edges are taken after it
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= pin_i;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign rise_o = sync_ff & ~prev_ff;
  assign fall_o = ~sync_ff & prev_ff;
endmodule // timer_sync

// ==== timer_channel.v ====
// One 8-bit timer channel: clock pick, counter, compare and flags
`timescale 1ns/10ps
`include "timer_ctl_defines.vh"
module timer_channel
(
  // Clock and reset
  input wire clk_i,
  input wire resetn_i,
  input wire standby_i,
  // Settings
  input wire [7:0] control_i,
  input wire src_bit_i,
  input wire chan1_i,
  input wire [7:0] match_a_i,
  input wire [7:0] match_b_i,
  input wire [`PRESCALE_W-1:0] prescale_i,
  input wire [`PRESCALE_W-1:0] prescale_fall_i,
  // External pin edges
  input wire ck_rise_i,
  input wire ck_fall_i,
  input wire clr_rise_i,
  // Software access
  input wire count_we_i,
  input wire flags_we_i,
  input wire flags_rd_i,
  input wire [7:0] wdata_i,
  // State
  output reg [7:0] count_o,
  output wire [7:0] flags_o,
  output wire ev_a_o,
  output wire ev_b_o,
  output wire ev_wrap_o
);
  reg [2:0] flag_ff;
  reg [2:0] seen_ff;
  reg tick;
  wire [2:0] cks;
  wire [1:0] clr_sel;
  wire hit_a;
  wire hit_b;
  wire set_a;
  wire set_b;
  wire set_w;
  wire clr_ext;
  wire [2:0] clr_req;

  assign cks = control_i[`CKS_HI:`CKS_LO];
  assign clr_sel = {control_i[`CLR_SEL_HI], control_i[`CLR_SEL_LO]};

  // Count pulse from the chosen source; internal taps count on falling edge
  always @*
  begin
    tick = 1'b0;
    case (cks)
      `CKS_INT_LO: tick = src_bit_i ? prescale_fall_i[`TAP_DIV2] :
        prescale_fall_i[`TAP_DIV8];
      `CKS_INT_MID: tick = chan1_i ?
        (src_bit_i ? prescale_fall_i[`TAP_DIV128] : prescale_fall_i[`TAP_DIV64]) :
        (src_bit_i ? prescale_fall_i[`TAP_DIV32] : prescale_fall_i[`TAP_DIV64]);
      `CKS_INT_HI: tick = chan1_i ?
        (src_bit_i ? prescale_fall_i[`TAP_DIV2048] : prescale_fall_i[`TAP_DIV1024]) :
        (src_bit_i ? prescale_fall_i[`TAP_DIV256] : prescale_fall_i[`TAP_DIV1024]);
      `CKS_EXT_RISE: tick = ck_rise_i;
      `CKS_EXT_FALL: tick = ck_fall_i;
      `CKS_EXT_BOTH: tick = ck_rise_i | ck_fall_i;
      default: tick = 1'b0;
    endcase
  end

  // Match is flagged in the last cycle it holds, as the count steps on
  assign hit_a = (count_o == match_a_i);
  assign hit_b = (count_o == match_b_i);
  assign set_a = hit_a & tick;
  assign set_b = hit_b & tick;
  assign set_w = tick & (count_o == 8'hFF);
  assign clr_ext = (clr_sel == `CLR_EXT) & clr_rise_i;

  // Counter: clear beats increment, software write beats both
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      count_o <= `COUNT_RST;
    else if (standby_i)
      count_o <= `COUNT_RST;
    else if (count_we_i)
      count_o <= wdata_i;
    else if (clr_ext || (tick && ((clr_sel == `CLR_MATCH_A && hit_a) ||
             (clr_sel == `CLR_MATCH_B && hit_b))))
      count_o <= `COUNT_RST;
    else if (tick)
      count_o <= count_o + 8'h01;
  end

  // Clear needs a prior read of 1 then write 0; a new set always wins
  assign clr_req = flags_we_i ? (seen_ff & ~wdata_i[7:5]) : 3'h0;
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      flag_ff <= 3'h0;
      seen_ff <= 3'h0;
    end
    else if (standby_i)
    begin
      flag_ff <= 3'h0;
      seen_ff <= 3'h0;
    end
    else
    begin
      flag_ff <= (flag_ff & ~clr_req) | {set_b, set_a, set_w};
      if (flags_rd_i)
        seen_ff <= flag_ff;
      else if (flags_we_i)
        seen_ff <= 3'h0;
    end
  end

  assign flags_o = {flag_ff, 5'h10};
  assign ev_a_o = set_a;
  assign ev_b_o = set_b;
  assign ev_wrap_o = set_w;
endmodule // timer_channel

// ==== timer_ctl.v ====
// Two-channel 8-bit timer: control registers, clock choice and interrupts
//
// Notes on behaviour
// - Each channel has an 8-bit control register, readable and writable.
// - Control register clears to zero on reset and in standby.
// - Bit 7 enables the match B interrupt from match flag B.
// - Bit 6 enables the match A interrupt from match flag A.
// - Bit 5 enables the wrap interrupt from the wrap flag.
// - Clear select: none, match A, match B, external clear rising edge.
// - Clock codes 000 and 100 give no clock; timer stopped.
// - Six internal prescaled sources per channel, picked with source bits.
// - Internal sources count on the falling edge of the prescaled clock.
// - Channel 0 divisors: 8/2, 64/32, 1024/256 by source bit 0.
// - External clock counts rising (101), falling (110) or both (111).
// - 8-bit up-counter; wrap from FF to 00 sets wrap flag.
// - Counter compared with both constants; equality sets match flag.
// - Match asserted in last state of match, as counter steps.
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/10ps
`include "timer_ctl_defines.vh"
module timer_ctl
(
  // Clock, reset and standby
  input wire clk_i,
  input wire resetn_i,
  input wire standby_i,
  // Register port
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // External pins per channel
  input wire [1:0] ext_count_clock_in_i,
  input wire [1:0] ext_counter_clear_in_i,
  // Per-channel interrupt requests
  output wire [1:0] match_a_irq_o,
  output wire [1:0] match_b_irq_o,
  output wire [1:0] wrap_irq_o,
  // Combined event interrupt
  output wire irq_o
);
  reg [7:0] control_ff [0:1];
  reg [7:0] match_a_ff [0:1];
  reg [7:0] match_b_ff [0:1];
  reg [7:0] src_sel_ff;
  reg [5:0] irq_stat_ff;
  reg [5:0] irq_mask_ff;
  reg [`PRESCALE_W-1:0] prescale_ff;
  reg [`PRESCALE_W-1:0] nxt_prescale;
  reg [7:0] nxt_rdata;
  wire [`PRESCALE_W-1:0] prescale_fall;
  wire [7:0] count [0:1];
  wire [7:0] flags [0:1];
  wire [5:0] events;
  wire [1:0] ck_rise;
  wire [1:0] ck_fall;
  wire [1:0] clr_rise;

  // Address decode used by writes and reads alike
  function hit;
    input [3:0] a;
    input [3:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  // Free-running prescaler; a tap falls when its bit drops from 1 to 0
  always @*
  begin
    nxt_prescale = prescale_ff + 11'h001;
  end
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      prescale_ff <= {`PRESCALE_W{1'b0}};
    else if (standby_i)
      prescale_ff <= {`PRESCALE_W{1'b0}};
    else
      prescale_ff <= nxt_prescale;
  end
  assign prescale_fall = prescale_ff & ~nxt_prescale;

  // Per-channel registers, synchronisers and counter logic
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_chan
      // Channel index as a sized constant; a genvar has no bits to select
      localparam [3:0] IDX = ch;
      localparam [3:0] IDX2 = ch * 2;
      wire sel_ctl;
      wire sel_a;
      wire sel_b;
      wire [5:0] ev;
      assign sel_ctl = hit(addr_i, `ADDR_CONTROL0 + IDX);
      assign sel_a = hit(addr_i, `ADDR_MATCH_A0 + IDX2);
      assign sel_b = hit(addr_i, `ADDR_MATCH_B0 + IDX2);

      // Control and constants; standby wipes them like reset
      always @(posedge clk_i or negedge resetn_i)
      begin
        if (!resetn_i)
        begin
          control_ff[ch] <= `CONTROL_RST;
          match_a_ff[ch] <= `MATCH_RST;
          match_b_ff[ch] <= `MATCH_RST;
        end
        else if (standby_i)
        begin
          control_ff[ch] <= `CONTROL_RST;
          match_a_ff[ch] <= `MATCH_RST;
          match_b_ff[ch] <= `MATCH_RST;
        end
        else if (wr_i)
        begin
          if (sel_ctl)
            control_ff[ch] <= wdata_i;
          if (sel_a)
            match_a_ff[ch] <= wdata_i;
          if (sel_b)
            match_b_ff[ch] <= wdata_i;
        end
      end

      timer_sync u_ck_sync
      (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .pin_i(ext_count_clock_in_i[ch]),
        .rise_o(ck_rise[ch]),
        .fall_o(ck_fall[ch])
      );
      timer_sync u_clr_sync
      (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .pin_i(ext_counter_clear_in_i[ch]),
        .rise_o(clr_rise[ch]),
        .fall_o()
      );

      timer_channel u_chan
      (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .standby_i(standby_i),
        .control_i(control_ff[ch]),
        .src_bit_i(src_sel_ff[ch]),
        .chan1_i(ch == 1),
        .match_a_i(match_a_ff[ch]),
        .match_b_i(match_b_ff[ch]),
        .prescale_i(prescale_ff),
        .prescale_fall_i(prescale_fall),
        .ck_rise_i(ck_rise[ch]),
        .ck_fall_i(ck_fall[ch]),
        .clr_rise_i(clr_rise[ch]),
        .count_we_i(wr_i & hit(addr_i, `ADDR_COUNT0 + IDX)),
        .flags_we_i(wr_i & hit(addr_i, `ADDR_FLAGS0 + IDX)),
        .flags_rd_i(rd_i & hit(addr_i, `ADDR_FLAGS0 + IDX)),
        .wdata_i(wdata_i),
        .count_o(count[ch]),
        .flags_o(flags[ch]),
        .ev_a_o(ev[0]),
        .ev_b_o(ev[1]),
        .ev_wrap_o(ev[2])
      );
      assign events[3*ch+2:3*ch] = ev[2:0];

      // Requests follow flag and enable as levels
      assign match_b_irq_o[ch] = flags[ch][`BIT_MATCH_B_FLAG] &
        control_ff[ch][`BIT_MATCH_B_IE];
      assign match_a_irq_o[ch] = flags[ch][`BIT_MATCH_A_FLAG] &
        control_ff[ch][`BIT_MATCH_A_IE];
      assign wrap_irq_o[ch] = flags[ch][`BIT_WRAP_FLAG] &
        control_ff[ch][`BIT_WRAP_IE];
    end
  endgenerate

  // Source select, event status and mask; a new event beats read-clear
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      src_sel_ff <= `SRC_SEL_RST;
      irq_stat_ff <= 6'h00;
      irq_mask_ff <= 6'h00;
    end
    else
    begin
      if (wr_i && hit(addr_i, `ADDR_SRC_SEL))
        src_sel_ff <= wdata_i;
      if (wr_i && hit(addr_i, `ADDR_IRQ_MASK))
        irq_mask_ff <= wdata_i[5:0];
      if (rd_i && hit(addr_i, `ADDR_IRQ_STAT))
        irq_stat_ff <= events;
      else
        irq_stat_ff <= irq_stat_ff | events;
    end
  end
  assign irq_o = |(irq_stat_ff & irq_mask_ff);

  // Read mux; unmapped addresses read zero
  always @*
  begin
    nxt_rdata = 8'h00;
    case (addr_i)
      `ADDR_CONTROL0: nxt_rdata = control_ff[0];
      `ADDR_CONTROL1: nxt_rdata = control_ff[1];
      `ADDR_MATCH_A0: nxt_rdata = match_a_ff[0];
      `ADDR_MATCH_B0: nxt_rdata = match_b_ff[0];
      `ADDR_MATCH_A1: nxt_rdata = match_a_ff[1];
      `ADDR_MATCH_B1: nxt_rdata = match_b_ff[1];
      `ADDR_COUNT0: nxt_rdata = count[0];
      `ADDR_COUNT1: nxt_rdata = count[1];
      `ADDR_FLAGS0: nxt_rdata = flags[0];
      `ADDR_FLAGS1: nxt_rdata = flags[1];
      `ADDR_SRC_SEL: nxt_rdata = src_sel_ff;
      `ADDR_IRQ_STAT: nxt_rdata = {2'h0, irq_stat_ff};
      `ADDR_IRQ_MASK: nxt_rdata = {2'h0, irq_mask_ff};
      default: nxt_rdata = 8'h00;
    endcase
  end

  // Read data held one cycle after the strobe
  always @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rdata_o <= 8'h00;
    else if (rd_i)
      rdata_o <= nxt_rdata;
    else
      rdata_o <= 8'h00;
  end
endmodule // timer_ctl

// ==== timer_ctl_assertions.sv ====
// Port-level assertions for the two-channel timer control block
`timescale 1ns/10ps
module timer_ctl_checker
(
  // Clock, reset and standby
  input wire clk_i,
  input wire resetn_i,
  input wire standby_i,
  // Register port
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  // Interrupt requests
  input wire [1:0] match_a_irq_o,
  input wire [1:0] match_b_irq_o,
  input wire [1:0] wrap_irq_o,
  input wire irq_o
);
  // One clock domain, so clocking and disable are shared
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // Register access and standby
  ctl_readback_a: assert property (
    wr_i && addr_i == 4'h0 && !standby_i ##1 rd_i && addr_i == 4'h0 && !standby_i
    |=> rdata_o == $past(wdata_i, 2)) else $error("control readback differs");
  idle_read_a: assert property (
    !rd_i |=> rdata_o == 8'h00) else $error("read data outside a read");
  standby_clear_a: assert property (
    standby_i && !wr_i ##1 rd_i && addr_i == 4'h0 && !standby_i
    |=> rdata_o == 8'h00) else $error("control kept through standby");
  standby_irq_a: assert property (
    standby_i |=> match_a_irq_o == 2'h0 && match_b_irq_o == 2'h0 && wrap_irq_o == 2'h0)
    else $error("request left after standby");
  // Enable bits gate the requests at once
  b_irq_gate_a: assert property (
    wr_i && addr_i == 4'h0 && !wdata_i[7] |=> !match_b_irq_o[0])
    else $error("match b request while disabled");
  a_irq_gate_a: assert property (
    wr_i && addr_i == 4'h1 && !wdata_i[6] |=> !match_a_irq_o[1])
    else $error("match a request while disabled");
  wrap_irq_gate_a: assert property (
    wr_i && addr_i == 4'h0 && !wdata_i[5] |=> !wrap_irq_o[0])
    else $error("wrap request while disabled");
  // Only a register write or standby may drop a request; a zero mask write drops the combined line
  irq_hold_a: assert property (
    match_a_irq_o[0] && !wr_i && !standby_i |=> match_a_irq_o[0])
    else $error("match a request dropped on its own");
  mask_off_a: assert property (
    wr_i && addr_i == 4'hC && wdata_i == 8'h00 |=> !irq_o [*2])
    else $error("combined request with all masked");

  // Main scenarios
  cover property (standby_i);
  cover property ($rose(irq_o));
  cover property (match_b_irq_o[0] && wrap_irq_o[1] == 1'b0);
endmodule // timer_ctl_checker

bind timer_ctl timer_ctl_checker timer_ctl_checker_inst (
  .clk_i(clk_i), .resetn_i(resetn_i), .standby_i(standby_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .match_a_irq_o(match_a_irq_o), .match_b_irq_o(match_b_irq_o),
  .wrap_irq_o(wrap_irq_o), .irq_o(irq_o));

// ==== timer_ctl_bench.sv ====
// Self-checking bench for the timer control block
`timescale 1ns/10ps
`include "timer_ctl_defines.vh"
module timer_ctl_bench;
  reg clk_i = 1'b0;
  reg resetn_i = 1'b0;
  reg standby_i = 1'b0;
  reg [3:0] addr_i = 4'h0;
  reg [7:0] wdata_i = 8'h00;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg [1:0] ck_pin = 2'h0;
  reg [1:0] clr_pin = 2'h0;
  wire [7:0] rdata_o;
  wire [1:0] match_a_irq_o;
  wire [1:0] match_b_irq_o;
  wire [1:0] wrap_irq_o;
  wire irq_o;
  wire [6:0] irqs = {irq_o, wrap_irq_o, match_b_irq_o, match_a_irq_o};
  int n_fail = 0;
  int compares = 0;
  int i;
  int s;
  int divs [12] = '{8, 2, 64, 32, 1024, 256, 8, 2, 64, 128, 1024, 2048};
  reg [7:0] v;
  reg [7:0] c;
  reg [7:0] got;

  // Device under test
  timer_ctl timer_ctl_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .standby_i(standby_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .ext_count_clock_in_i(ck_pin), .ext_counter_clear_in_i(clr_pin),
    .match_a_irq_o(match_a_irq_o), .match_b_irq_o(match_b_irq_o),
    .wrap_irq_o(wrap_irq_o), .irq_o(irq_o));

  // 125 MHz system clock
  always #4 clk_i = ~clk_i;

  task test_done;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input [7:0] seen, input [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Bus cycles; the trailing delay lets the edge's updates settle
  task wr(input [3:0] a, input [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  task rd(input [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 got = rdata_o;
  endtask

  // Write then read with no gap between the strobes
  task wrrd(input [3:0] a, input [7:0] d);
    wr(a, d);
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 got = rdata_o;
  endtask

  task wait_irq(input int b, input int n);
    int k;
    for (k = 0; k < n && irqs[b] !== 1'b1; k++)
      @(posedge clk_i) #1;
    chk(irqs[b], 1'b1);
    if (irqs[b] !== 1'b1)
      test_done;
  endtask

  // Slow pulses on the channel 0 count pin, then time for the synchroniser
  task pulse(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      ck_pin[0] <= 1'b1;
      repeat (4) @(posedge clk_i);
      ck_pin[0] <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    repeat (5) @(posedge clk_i);
  endtask

  function [7:0] ext_exp(input [2:0] code, input int n);
    ext_exp = (code == 3'h7) ? 8'(2 * n) : (code[2] && code != 3'h4) ? 8'(n) : 8'h00;
  endfunction

  // Main sequence
  initial
  begin
    v = $urandom(13);
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(`ADDR_CONTROL0);
    chk(got, `CONTROL_RST);
    rd(`ADDR_CONTROL1);
    chk(got, `CONTROL_RST);
    for (i = 0; i < 12; i++)
    begin
      v = $urandom;
      wrrd(i < 9 ? 4'(i % 2) : 4'hD + 4'(i % 3), v);
      chk(got, i < 9 ? v : 8'h00);
    end
    @(posedge clk_i);
    standby_i <= 1'b1;
    @(posedge clk_i);
    standby_i <= 1'b0;
    addr_i <= `ADDR_CONTROL0;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, `CONTROL_RST);
    $display("test registers done");
    wr(`ADDR_SRC_SEL, 8'h01);
    for (s = 0; s < 2; s++)
    begin
      wr(`ADDR_COUNT0, 8'h00);
      wr(`ADDR_MATCH_A0, s ? 8'hFF : 8'h05);
      wr(`ADDR_MATCH_B0, s ? 8'h05 : 8'hFF);
      rd(`ADDR_IRQ_STAT);
      v = 8'(8'h40 << s) | 8'((s + 1) << 3);
      wr(`ADDR_CONTROL0, v | 8'h01);
      wait_irq(2 * s, 40);
      wr(`ADDR_CONTROL0, v);
      rd(`ADDR_COUNT0);
      c = got;
      chk(c <= 8'h05, 1'b1);
      repeat (20) @(posedge clk_i);
      rd(`ADDR_COUNT0);
      chk(got, c);
      wr(`ADDR_CONTROL0, v & 8'h3F);
      chk(irqs[2 * s], 1'b0);
      wr(`ADDR_CONTROL0, v);
      chk(irqs[2 * s], 1'b1);
      wr(`ADDR_IRQ_MASK, 8'(1 << s));
      chk(irq_o, 1'b1);
      wr(`ADDR_IRQ_MASK, 8'h00);
      chk(irq_o, 1'b0);
      wr(`ADDR_IRQ_MASK, 8'(1 << s));
      rd(`ADDR_IRQ_STAT);
      chk(irq_o, 1'b0);
      wr(`ADDR_FLAGS0, 8'h00);
      chk(irqs[2 * s], 1'b1);
      rd(`ADDR_FLAGS0);
      chk(got, 8'h10 | 8'(8'h40 << s));
      wr(`ADDR_FLAGS0, 8'h00);
      chk(irqs[2 * s], 1'b0);
    end
    wr(`ADDR_FLAGS0, 8'hE0);
    rd(`ADDR_FLAGS0);
    chk(got & 8'hF0, 8'h10);
    $display("test match and interrupts done");
    wr(`ADDR_SRC_SEL, 8'h02);
    wr(`ADDR_COUNT1, 8'hF0);
    wr(`ADDR_CONTROL1, 8'h21);
    wait_irq(5, 80);
    wr(`ADDR_CONTROL1, 8'h01);
    chk(irqs[5], 1'b0);
    rd(`ADDR_COUNT1);
    chk(got < 8'h40, 1'b1);
    for (i = 0; i < 12; i++)
    begin
      s = i / 6;
      wr(`ADDR_CONTROL0 + 4'(s), 8'h00);
      wr(`ADDR_COUNT0 + 4'(s), 8'h00);
      wr(`ADDR_SRC_SEL, 8'((i % 2) << s));
      wr(`ADDR_CONTROL0 + 4'(s), 8'((i % 6) / 2 + 1));
      repeat (3 * divs[i]) @(posedge clk_i);
      rd(`ADDR_COUNT0 + 4'(s));
      chk(got >= 8'h02 && got <= 8'(4 + 3 / divs[i]), 1'b1);
    end
    $display("test prescaler done");
    for (i = 0; i < 5; i++)
    begin
      c = (i == 0) ? 8'h00 : 8'(3 + i);
      wr(`ADDR_CONTROL0, c);
      wr(`ADDR_COUNT0, 8'h00);
      pulse(3);
      rd(`ADDR_COUNT0);
      chk(got, ext_exp(c[2:0], 3));
    end
    wr(`ADDR_CONTROL0, 8'h1D);
    pulse(2);
    @(posedge clk_i);
    clr_pin[0] <= 1'b1;
    repeat (6) @(posedge clk_i);
    clr_pin[0] <= 1'b0;
    rd(`ADDR_COUNT0);
    chk(got, 8'h00);
    $display("test external pins done");
    test_done;
  end
endmodule // timer_ctl_bench
